// >>> src/host_port_pkg.sv
// Shared constants and carriers for the host bus port
`default_nettype none
package host_port_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int NUM_CH = 8;
    localparam int NUM_REG = 16;
    localparam int REG_LSB = 0;
    localparam int REG_MSB = 3;
    localparam int CH_LSB = 4;
    localparam int CH_MSB = 6;
    localparam int GLOBAL_BIT = 7;
    localparam int NUM_GLOBAL = 16;
    // Global register offsets inside the global page
    localparam logic [3:0] GLB_INT_SRC = 4'h0;
    localparam logic [3:0] GLB_SCRATCH = 4'h1;
    localparam logic [7:0] REG_RESET = 8'h00;

    typedef struct packed {
        logic readStrobeN;
        logic writeStrobeN;
        logic chipSelectN;
        logic sepStrobeStyle;
        logic [ADDR_W-1:0] registerAddressLines;
        logic [DATA_W-1:0] hostDataIn;
    } bus_in_t;

    typedef struct packed {
        logic [DATA_W-1:0] hostDataOut;
        logic hostDataOe;
        logic interruptOe;
    } bus_out_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_READ = 2'b01,
        ST_WRITE = 2'b10
    } access_t;
endpackage
`default_nettype wire

// >>> src/channel_regs.sv
// One channel's sixteen-byte register set
`timescale 1ns/1ps
`default_nettype none
module channel_regs (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic writeEn,
    input wire logic [3:0] regIndex,
    input wire logic [7:0] writeData,
    input wire logic [3:0] readIndex,
    output logic [7:0] readData,
    output logic irqPending
);
    typedef struct packed {
        logic [host_port_pkg::NUM_REG-1:0][7:0] regs;
    } chan_state_t;
    chan_state_t state;
    chan_state_t next_state;

    always_comb
    begin
        next_state = state;
        if (writeEn)
        begin
            next_state.regs[regIndex] = writeData;
        end
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign readData = state.regs[readIndex];
    // Register 1 stands in for the enable word; stub source pending channel logic
    assign irqPending = |(state.regs[1] & state.regs[2]);
endmodule
`default_nettype wire

// >>> src/octal_uart_host_bus_port.sv
// Host parallel bus port with channel decode and global interrupt
// How it works
// - Address bits 3:0 pick register, 6:4 pick channel, bit 7 global page.
// - Separate-strobe style: read strobe fall latches addressed byte, drives data bus.
// - Separate-strobe style: write strobe fall starts, rising edge stores bus byte.
// - Combined style: write strobe pin is direction, high read, low write.
// - Select pin is chip select, or combined active-low strobe in other style.
// - Interrupt output is open drain, pulled low only when asserted.
// - Global source register shows all eight channel interrupt flags.
// - Eight-bit data bus takes write data and carries read data.
// - Each channel keeps its own independent register set.
`timescale 1ns/1ps
`default_nettype none
module octal_uart_host_bus_port (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic sepStrobeStyle,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic chipSelectN,
    input wire logic [7:0] register_address_lines,
    input wire logic [7:0] hostDataIn,
    output logic [7:0] host_data_lines,
    output logic hostDataOe,
    output logic interruptOe
);
    typedef struct packed {
        host_port_pkg::access_t access;
        logic [7:0] addr;
        logic [7:0] rdData;
        logic [7:0] scratch;
    } port_state_t;
    port_state_t state;
    port_state_t next_state;

    logic readActive;
    logic writeActive;
    logic writeEnd;
    logic [7:0] chWe;
    logic [7:0][7:0] chData;
    logic [7:0] chIrq;
    logic [7:0] selData;
    logic [2:0] chSel;
    logic isGlobal;

    // Decode the access in progress from the strobe style
    always_comb
    begin
        if (sepStrobeStyle)
        begin
            // Strobes ignored while not selected; read strobe ignored in other style
            readActive = !chipSelectN && !read_strobe_n;
            writeActive = !chipSelectN && !write_strobe_n;
        end
        else
        begin
            readActive = !chipSelectN && write_strobe_n;
            writeActive = !chipSelectN && !write_strobe_n;
        end
    end

    assign chSel = register_address_lines[host_port_pkg::CH_MSB:host_port_pkg::CH_LSB];
    assign isGlobal = register_address_lines[host_port_pkg::GLOBAL_BIT];
    // Write completes on the strobe's trailing edge, using captured address
    assign writeEnd = (state.access == host_port_pkg::ST_WRITE) && !writeActive;

    always_comb
    begin
        selData = 8'h00;
        if (isGlobal)
        begin
            case (register_address_lines[3:0])
                host_port_pkg::GLB_INT_SRC: selData = chIrq;
                host_port_pkg::GLB_SCRATCH: selData = state.scratch;
                default: selData = 8'h00;
            endcase
        end
        else
        begin
            selData = chData[chSel];
        end
    end

    always_comb
    begin
        next_state = state;
        case (state.access)
            host_port_pkg::ST_IDLE:
            begin
                if (readActive)
                begin
                    next_state.access = host_port_pkg::ST_READ;
                    next_state.rdData = selData;
                end
                else if (writeActive)
                begin
                    next_state.access = host_port_pkg::ST_WRITE;
                    next_state.addr = register_address_lines;
                    // Sample now: a one-cycle strobe offers no later chance
                    next_state.rdData = hostDataIn;
                end
            end
            host_port_pkg::ST_READ:
            begin
                if (!readActive)
                begin
                    next_state.access = host_port_pkg::ST_IDLE;
                end
            end
            host_port_pkg::ST_WRITE:
            begin
                // Sample data only while the strobe is low; host may release both together
                if (writeActive)
                begin
                    next_state.rdData = hostDataIn;
                end
                if (!writeActive)
                begin
                    next_state.access = host_port_pkg::ST_IDLE;
                    if (state.addr[host_port_pkg::GLOBAL_BIT]
                        && state.addr[3:0] == host_port_pkg::GLB_SCRATCH)
                    begin
                        next_state.scratch = state.rdData;
                    end
                end
            end
            default: next_state.access = host_port_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    // Channel write enable, one per channel, on trailing edge only
    always_comb
    begin
        chWe = 8'h00;
        if (writeEnd && !state.addr[host_port_pkg::GLOBAL_BIT])
        begin
            chWe[state.addr[6:4]] = 1'b1;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < host_port_pkg::NUM_CH; gi++)
        begin : g_ch
            channel_regs u_ch (
                .core_clk(core_clk),
                .rstn(rstn),
                .writeEn(chWe[gi]),
                .regIndex(state.addr[3:0]),
                .writeData(state.rdData),
                .readIndex(register_address_lines[3:0]),
                .readData(chData[gi]),
                .irqPending(chIrq[gi])
            );
        end
    endgenerate

    assign host_data_lines = state.access == host_port_pkg::ST_READ ? state.rdData : 8'h00;
    assign hostDataOe = (state.access == host_port_pkg::ST_READ) && readActive;
    assign interruptOe = |chIrq;

    a_bus_released: assert property (@(posedge core_clk) disable iff (!rstn)
        hostDataOe |-> !chipSelectN
        && (sepStrobeStyle ? !read_strobe_n : write_strobe_n))
        else $error("data bus driven outside read");
    a_read_start: assert property (@(posedge core_clk) disable iff (!rstn)
        (state.access == host_port_pkg::ST_IDLE && readActive) |=> hostDataOe || !readActive)
        else $error("read did not drive bus");
    a_unselected_idle: assert property (@(posedge core_clk) disable iff (!rstn)
        (chipSelectN && state.access == host_port_pkg::ST_IDLE)
        |=> state.access == host_port_pkg::ST_IDLE)
        else $error("access started while unselected");
    a_write_end: assert property (@(posedge core_clk) disable iff (!rstn)
        (state.access == host_port_pkg::ST_WRITE && !writeActive) |=> state.access == host_port_pkg::ST_IDLE)
        else $error("write not closed on trailing edge");
    a_single_channel: assert property (@(posedge core_clk) disable iff (!rstn)
        $onehot0(chWe))
        else $error("more than one channel written");
    a_irq_drive: assert property (@(posedge core_clk) disable iff (!rstn)
        interruptOe == (chIrq != 8'h00))
        else $error("interrupt pin mismatch");
    a_dir_read: assert property (@(posedge core_clk) disable iff (!rstn)
        (!sepStrobeStyle && !chipSelectN && write_strobe_n
        && state.access == host_port_pkg::ST_IDLE)
        |=> state.access == host_port_pkg::ST_READ)
        else $error("direction high did not read");
    a_global_src: assert property (@(posedge core_clk) disable iff (!rstn)
        (state.access == host_port_pkg::ST_IDLE && readActive && isGlobal
        && register_address_lines[3:0] == host_port_pkg::GLB_INT_SRC)
        |=> state.rdData == $past(chIrq))
        else $error("global source read wrong");
endmodule
`default_nettype wire

// >>> tb/host_bus_model.sv
// Host processor model driving the parallel bus port
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
    input wire logic core_clk,
    input wire logic [7:0] host_data_lines,
    input wire logic hostDataOe,
    output var host_port_pkg::bus_in_t bus
);
    initial bus = '{1'b1, 1'b1, 1'b1, 1'b1, 8'h00, 8'h00};
    task automatic set_style(input logic s);
        @(posedge core_clk);
        bus.sepStrobeStyle <= s;
    endtask
    task automatic access(input logic wr, input logic sel, input logic [7:0] a,
        input logic [7:0] d, output logic [7:0] q, output logic ack);
        int n;
        @(posedge core_clk);
        bus.registerAddressLines <= a;
        bus.hostDataIn <= wr ? d : ~bus.hostDataIn;
        bus.chipSelectN <= !sel;
        if (bus.sepStrobeStyle)
        begin
            bus.writeStrobeN <= !wr;
            bus.readStrobeN <= wr;
        end
        else
            bus.writeStrobeN <= !wr;
        n = 0;
        ack = 1'b0;
        do
        begin
            @(posedge core_clk);
            n++;
            ack = hostDataOe;
        end while (!wr && ack !== 1'b1 && n < 6);
        q = host_data_lines;
        bus.chipSelectN <= 1'b1;
        bus.writeStrobeN <= 1'b1;
        bus.readStrobeN <= 1'b1;
        // Released bus must not keep showing the old byte
        bus.hostDataIn <= ~bus.hostDataIn;
        repeat (3) @(posedge core_clk);
    endtask
endmodule
`default_nettype wire

// >>> tb/octal_uart_host_bus_port_test.sv
// Self-checking bench for the host bus port
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) begin totalChecks++; if ((got) !== (exp)) begin errorCnt++; \
    $display("Error %s expected %0h seen %0h", what, exp, got); end end
module octal_uart_host_bus_port_test;
    logic core_clk;
    logic rstn;
    host_port_pkg::bus_in_t bus;
    logic [7:0] hdl;
    logic oe;
    logic irqOe;
    wire logic intLine;
    int errorCnt;
    int totalChecks;
    logic [7:0] mem [256];
    assign intLine = irqOe ? 1'b0 : 1'b1;
    host_bus_model i_host (.core_clk(core_clk), .host_data_lines(hdl), .hostDataOe(oe),
        .bus(bus));
    octal_uart_host_bus_port i_dut (.core_clk(core_clk), .rstn(rstn),
        .sepStrobeStyle(bus.sepStrobeStyle), .read_strobe_n(bus.readStrobeN),
        .write_strobe_n(bus.writeStrobeN), .chipSelectN(bus.chipSelectN),
        .register_address_lines(bus.registerAddressLines), .hostDataIn(bus.hostDataIn),
        .host_data_lines(hdl), .hostDataOe(oe), .interruptOe(irqOe));
    function automatic logic [7:0] src();
        logic [7:0] s;
        s = 8'h00;
        for (int ch = 0; ch < 8; ch++)
            s[ch] = |(mem[ch * 16 + 1] & mem[ch * 16 + 2]);
        return s;
    endfunction
    function automatic logic [7:0] expect_rd(logic [7:0] a);
        if (!a[7])
            return mem[a];
        if (a[3:0] == 4'h0)
            return src();
        return (a[3:0] == 4'h1) ? mem[8'h81] : 8'h00;
    endfunction
    task automatic xfer(input logic wr, input logic sel, input logic [7:0] a,
        input logic [7:0] d);
        logic [7:0] q;
        logic ack;
        i_host.access(wr, sel, a, d, q, ack);
        if (wr && sel)
            mem[a] = d;
        if (!wr)
        begin
            `CHK("read enable", sel, ack)
            if (sel)
                `CHK("read data", expect_rd(a), q)
        end
        `CHK("interrupt line", ~|src(), intLine)
    endtask
    task automatic reportAndStop();
        if (errorCnt == 0 && totalChecks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    initial
    begin
        repeat (20000) @(posedge core_clk);
        errorCnt++;
        reportAndStop();
    end
    initial
    begin
        logic [7:0] a;
        errorCnt = 0;
        totalChecks = 0;
        rstn = 1'b0;
        foreach (mem[i])
            mem[i] = 8'h00;
        void'($urandom(77));
        repeat (12) @(posedge core_clk);
        `CHK("reset oe", 1'b0, oe)
        `CHK("reset irq", 1'b0, irqOe)
        rstn <= 1'b1;
        for (int s = 1; s >= 0; s--)
        begin
            i_host.set_style(s[0]);
            for (int i = 0; i < 30; i++)
                xfer(1'b1, 1'b1, 8'($urandom % 128), 8'($urandom));
            for (int i = 0; i < 30; i++)
                xfer(1'b0, 1'b1, 8'($urandom % 128), 8'h00);
            a = 8'($urandom % 128);
            // Unselected strobes must leave registers and bus alone
            xfer(1'b1, 1'b0, a, ~mem[a]);
            xfer(1'b0, 1'b0, a, 8'h00);
            xfer(1'b0, 1'b1, a, 8'h00);
            xfer(1'b1, 1'b1, 8'h81, 8'($urandom));
            for (int ch = 0; ch < 8; ch++)
            begin
                xfer(1'b1, 1'b1, 8'(ch * 16 + 1), 8'hFF);
                xfer(1'b1, 1'b1, 8'(ch * 16 + 2), 8'(1 << ch));
                xfer(1'b0, 1'b1, 8'h80, 8'h00);
                xfer(1'b1, 1'b1, 8'(ch * 16 + 2), 8'h00);
            end
            xfer(1'b0, 1'b1, 8'h81, 8'h00);
            xfer(1'b0, 1'b1, 8'h8F, 8'h00);
        end
        reportAndStop();
    end
endmodule
`default_nettype wire
